// file: include/fir_rate_pkg.sv
// Purpose: Shared types and constants of the FIR rate and reload block
// Assumes: 32-bit APB register words, one clock
// Notes:   Field positions come from the packed register structs
package fir_rate_pkg;
    localparam int DW    = 16;
    localparam int CW    = 16;
    localparam int DEPTH = 16;
    localparam int SETS  = 2;
    localparam int AW    = 4;
    localparam int CHW   = 4;

    typedef enum logic [1:0] {
        ARCH_PARALLEL               = 2'h0,
        ARCH_TIME_SHARED_MULTICYCLE = 2'h1,
        ARCH_SERIAL                 = 2'h2,
        ARCH_MULTIBIT_SERIAL        = 2'h3
    } arch_t;

    typedef enum logic [1:0] {
        RATE_SINGLE = 2'h0,
        RATE_INTERP = 2'h1,
        RATE_DECIM  = 2'h2
    } rate_t;

    // Gray order along idle -> take -> emit -> take
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_TAKE = 2'h1,
        ST_EMIT = 2'h3
    } state_t;

    typedef struct packed {
        logic [26:0] reserved;
        logic        logic_cells;
        rate_t       rate;
        arch_t       arch;
    } mode_t;

    typedef struct packed {
        logic [7:0] reserved_hi;
        logic [3:0] channels_m1;
        logic       reserved_mid;
        logic [2:0] serial_units;
        logic [1:0] reserved_lo;
        logic [5:0] in_width;
        logic [3:0] compute_cycles;
        logic [3:0] factor;
    } shape_t;

    typedef struct packed {
        logic [21:0]   reserved;
        logic          load_set;
        logic          restore_pending;
        logic          loading;
        logic [AW-1:0] reload_addr;
        state_t        state;
        logic          out_valid;
    } status_t;

    typedef struct packed {
        logic [DW-1:0]  data;
        logic           sop;
        logic           eop;
        logic [CHW-1:0] chan;
    } beat_t;

    localparam logic [11:0] MODE_OFF   = 12'h000;
    localparam logic [11:0] SHAPE_OFF  = 12'h004;
    localparam logic [11:0] STATUS_OFF = 12'h008;
    localparam logic [11:0] COUNT_OFF  = 12'h00c;

    localparam logic [31:0] MODE_RESET  = 32'h0000_0011;
    localparam logic [31:0] SHAPE_RESET = 32'h0002_0812;
    localparam logic [31:0] MODE_MASK   = 32'h0000_001f;
    localparam logic [31:0] SHAPE_MASK  = 32'h00f7_3fff;

    localparam logic [1:0] LEAD_MEM = 2'h2;
    localparam logic [1:0] LEAD_PAR = 2'h1;

    // Built-in set; entry zero stays zero like any lookup table
    function automatic logic [CW-1:0] builtin_coef(input int idx);
        return (idx == 0) ? '0 : CW'(idx);
    endfunction
endpackage

// file: verilog/fir_rate_core.sv
// Purpose: Sample-rate engine and coefficient reload of a FIR core
// Assumes: Inputs synchronous to pclk; reload shares pclk
// Notes:   Arithmetic is one polyphase product per output
// ------------------------------------------------------------
// Overview of operation
// - Interpolate-by-two emits exactly two outputs per accepted input.
// - Single-cycle interpolate-by-two outputs every cycle, takes input every other.
// - Time-shared interpolator takes one input per NxM cycles, M outputs each.
// - Decimator emits one output per M accepted inputs.
// - Single-cycle decimate-by-two takes input each cycle, outputs every second.
// - Decimator takes one input per N cycles, one output per NxM.
// - Two serial units, 8-bit input, decimate-by-two: input per four cycles, output per eight.
// - Output sop marks first channel, eop last channel, channel field names it.
// - Reload port ignores reset, clock enable and stream control.
// - Rising write enable clears the reload address counter.
// - Reload logic runs from pclk; it has no reload clock of its own.
// - Reset restores built-in coefficients when held in logic cells.
// - One set may be rewritten while another computes.
// - Compute-set change acts at once, not aligned to samples.
// - Input moves only on an edge with ready and valid both high.
// - Serial needs input per width+1 cycles; multibit per width/units.
// ------------------------------------------------------------
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/10ps
module fir_rate_core (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            ce,
    input  wire logic [11:0]                     paddr,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [31:0]                     pwdata,
    output      logic [31:0]                     prdata,
    output      logic                            pready,
    output      logic                            pslverr,
    input  wire logic                            in_valid,
    output      logic                            in_ready,
    input  wire logic [fir_rate_pkg::DW-1:0]     in_data,
    output      logic                            out_valid,
    input  wire logic                            out_ready,
    output      fir_rate_pkg::beat_t             out_beat,
    input  wire logic                            coeff_we,
    input  wire logic [fir_rate_pkg::CW-1:0]     coeff_data_in,
    input  wire logic                            coeff_load_set,
    input  wire logic                            coeff_compute_set
);
    import fir_rate_pkg::*;

    // ------------------------------------------------------------
    // Registers and APB slave
    // ------------------------------------------------------------
    mode_t         mode;
    shape_t        shape;
    state_t        state;
    logic [15:0]   in_count;
    logic [15:0]   out_count;
    status_t       status;
    logic [31:0]   rd_mux;
    logic          restore_pending;
    logic          load_set_q;
    logic          we_q = 1'b0;
    logic [1:0]    lead = 2'h0;
    logic [AW-1:0] addr = '0;

    wire wr_mode  = psel & penable & pwrite & (paddr == MODE_OFF);
    wire wr_shape = psel & penable & pwrite & (paddr == SHAPE_OFF);
    wire hit      = (paddr == MODE_OFF) | (paddr == SHAPE_OFF)
                  | (paddr == STATUS_OFF) | (paddr == COUNT_OFF);

    assign rd_mux = (paddr == MODE_OFF)   ? mode :
                    (paddr == SHAPE_OFF)  ? shape :
                    (paddr == STATUS_OFF) ? status :
                    (paddr == COUNT_OFF)  ? {out_count, in_count} : 32'h0000_0000;
    assign prdata  = psel ? rd_mux : 32'h0000_0000;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode  <= MODE_RESET;
            shape <= SHAPE_RESET;
        end else begin
            if (wr_mode)
                mode <= pwdata & MODE_MASK;
            if (wr_shape)
                shape <= pwdata & SHAPE_MASK;
        end
    end

    // ------------------------------------------------------------
    // Rate arithmetic
    // ------------------------------------------------------------
    logic [6:0]  n_base;
    logic [3:0]  fac;
    logic [2:0]  units;
    logic [10:0] in_period;
    logic [10:0] out_period;

    assign units = (shape.serial_units == 3'h0) ? 3'h1 : shape.serial_units;
    assign fac   = (mode.rate == RATE_SINGLE || shape.factor == 4'h0) ? 4'h1 : shape.factor;
    assign n_base =
        (mode.arch == ARCH_PARALLEL) ? 7'h01 :
        (mode.arch == ARCH_TIME_SHARED_MULTICYCLE) ?
            ((shape.compute_cycles == 4'h0) ? 7'h01 : {3'h0, shape.compute_cycles}) :
        (mode.arch == ARCH_SERIAL) ? {1'b0, shape.in_width} + 7'h01 :
            7'({1'b0, shape.in_width} / {4'h0, units});
    assign in_period  = (mode.rate == RATE_INTERP) ? 11'(n_base * fac)
                                                    : {4'h0, n_base};
    assign out_period = (mode.rate == RATE_DECIM) ? 11'(n_base * fac)
                                                   : {4'h0, n_base};

    // ------------------------------------------------------------
    // Rate engine
    // ------------------------------------------------------------
    logic [10:0]    gap;
    logic [3:0]     phase;
    logic [3:0]     dec_cnt;
    logic [DW-1:0]  sample;
    logic [DW-1:0]  acc;
    logic [CHW-1:0] chan;
    logic [DW-1:0]  operand;
    logic [CW-1:0]  coef;
    logic [3:0]     csel;
    logic [DW+CW-1:0] prod;
    logic [CW-1:0]  coef_mem [SETS*DEPTH];

    // Output stall freezes the engine rather than dropping a sample
    wire stall     = out_valid & ~out_ready;
    wire slot_open = ce & (state != ST_IDLE) & (gap == 11'h000) & ~stall;
    assign in_ready = slot_open & (state == ST_TAKE);
    wire accept    = in_ready & in_valid;
    wire emit      = slot_open & (state == ST_EMIT);
    wire dec_done  = (mode.rate == RATE_DECIM) & (dec_cnt == fac - 4'h1);
    wire load      = (accept & ((mode.rate != RATE_DECIM) | dec_done)) | emit;
    wire last_ch   = (chan == shape.channels_m1);

    assign csel    = emit ? phase + 4'h1 : 4'h1;
    // Set selector is not aligned to samples; it bites at once
    assign coef    = coef_mem[{coeff_compute_set, csel}];
    assign operand = emit ? sample :
                     (mode.rate == RATE_DECIM) ? DW'(acc + in_data) : in_data;
    assign prod    = operand * coef;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= ST_IDLE;
            gap     <= 11'h000;
            phase   <= 4'h0;
            dec_cnt <= 4'h0;
            sample  <= '0;
            acc     <= '0;
        end else if (ce) begin
            if (state == ST_IDLE)
                state <= ST_TAKE;
            if (accept || emit)
                gap <= {4'h0, n_base} - 11'h001;
            else if (gap != 11'h000)
                gap <= gap - 11'h001;
            if (accept && mode.rate == RATE_INTERP) begin
                sample <= in_data;
                phase  <= 4'h1;
                state  <= (fac > 4'h1) ? ST_EMIT : ST_TAKE;
            end
            if (emit) begin
                phase <= phase + 4'h1;
                if (phase == fac - 4'h1)
                    state <= ST_TAKE;
            end
            if (accept && mode.rate == RATE_DECIM) begin
                acc     <= dec_done ? '0 : DW'(acc + in_data);
                dec_cnt <= dec_done ? 4'h0 : dec_cnt + 4'h1;
            end
            // New setup starts a fresh group, no stale partial sum
            if (wr_mode || wr_shape) begin
                acc     <= '0;
                dec_cnt <= 4'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_beat  <= '0;
            chan      <= '0;
        end else if (ce) begin
            if (load) begin
                out_valid     <= 1'b1;
                out_beat.data <= prod[DW+CW-2 -: DW];
                out_beat.chan <= chan;
                out_beat.sop  <= (chan == '0);
                out_beat.eop  <= last_ch;
                chan          <= last_ch ? '0 : chan + 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (wr_shape)
                chan <= '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_count  <= 16'h0000;
            out_count <= 16'h0000;
        end else begin
            if (accept)
                in_count <= in_count + 16'h0001;
            if (out_valid && out_ready && ce)
                out_count <= out_count + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Coefficient reload
    // ------------------------------------------------------------
    // No reset and no enable here, so loading works while held
    wire       rise     = coeff_we & ~we_q;
    wire       wr       = coeff_we & ~rise & (lead == 2'h0);
    wire [1:0] lead_len = (mode.arch == ARCH_PARALLEL) ? LEAD_PAR : LEAD_MEM;

    // Reload rides pclk; an own reload clock needs a crossing first
    always_ff @(posedge pclk) begin
        we_q <= coeff_we;
        if (rise) begin
            addr       <= '0;
            lead       <= lead_len - 2'h1;
            load_set_q <= coeff_load_set;
        end else if (coeff_we && lead != 2'h0) begin
            lead <= lead - 2'h1;
        end else if (wr) begin
            addr <= addr + 1'b1;
        end
    end

    // Stays set through reset, cleared at the first edge after it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            restore_pending <= 1'b1;
        else
            restore_pending <= 1'b0;
    end

    for (genvar i = 0; i < SETS * DEPTH; i++) begin : g_coef
        always_ff @(posedge pclk) begin
            if (wr && {load_set_q, addr} == 5'(i))
                coef_mem[i] <= coeff_data_in;
            else if (restore_pending && mode.logic_cells)
                coef_mem[i] <= builtin_coef(i % DEPTH);
        end
    end

    assign status = '{reserved: '0, load_set: load_set_q,
                      restore_pending: restore_pending, loading: coeff_we,
                      reload_addr: addr, state: state, out_valid: out_valid};

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [11:0] since_acc;
    logic [11:0] since_load;
    logic [4:0]  loads_since;
    logic [4:0]  acc_since;
    logic        seen_acc;
    logic        seen_load;
    wire         cfg_wr = wr_mode | wr_shape;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_acc   <= 12'h000;
            since_load  <= 12'h000;
            loads_since <= 5'h00;
            acc_since   <= 5'h00;
            seen_acc    <= 1'b0;
            seen_load   <= 1'b0;
        end else begin
            since_acc  <= accept ? 12'h001 : since_acc + {11'h000, ~&since_acc};
            since_load <= load ? 12'h001 : since_load + {11'h000, ~&since_load};
            seen_acc   <= (seen_acc | accept) & ~cfg_wr;
            seen_load  <= (seen_load | load) & ~cfg_wr;
            if (accept)
                loads_since <= 5'h01;
            else if (load)
                loads_since <= loads_since + 5'h01;
            if (load)
                acc_since <= 5'h00;
            else if (accept)
                acc_since <= acc_since + 5'h01;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    in_spacing_a: assert property (accept && seen_acc |-> since_acc >= {1'b0, in_period})
        else $error("input taken before its slot");
    out_spacing_a: assert property (load && seen_load |-> since_load >= {1'b0, out_period})
        else $error("output produced before its slot");
    interp_count_a: assert property (accept && seen_acc && mode.rate == RATE_INTERP
        |-> loads_since == {1'b0, fac})
        else $error("wrong output count per input");
    decim_group_a: assert property (load && seen_load && mode.rate == RATE_DECIM
        |-> acc_since + 5'h01 == {1'b0, fac})
        else $error("wrong input count per output");
    sop_first_a: assert property (out_valid && out_beat.sop |-> out_beat.chan == '0)
        else $error("sop not on first channel");
    eop_last_a: assert property (out_valid && out_beat.eop
        |-> out_beat.chan == shape.channels_m1)
        else $error("eop not on last channel");
    out_hold_a: assert property (out_valid && !out_ready
        |=> out_valid && $stable(out_beat))
        else $error("output dropped while stalled");
    addr_clear_a: assert property (rise |=> addr == '0 ##1 addr == AW'($past(wr)))
        else $error("reload address not cleared");
    addr_step_a: assert property (wr |=> addr == $past(addr) + 1'b1)
        else $error("reload address did not advance");

    interp_cov: cover property (accept && seen_acc && mode.rate == RATE_INTERP);
    decim_cov: cover property (load && mode.rate == RATE_DECIM && seen_load);
    reload_cov: cover property (rise ##2 wr [*3]);
    stall_cov: cover property (stall ##1 out_ready);
endmodule

// file: testbench/fir_partner.sv
// Purpose: Producer, consumer and coefficient loader facing the core
// Assumes: Bench calls load from its own sequence on pclk edges
// Notes:   Idle data lines show inverted values, never a stale sample
`timescale 1ns/10ps
module fir_partner (
    input  wire logic                        pclk,
    input  wire logic                        src_on,
    input  wire logic                        sink_on,
    input  wire logic [fir_rate_pkg::DW-1:0] src_value,
    input  wire logic                        in_ready,
    output      logic                        in_valid,
    output      logic [fir_rate_pkg::DW-1:0] in_data,
    output      logic                        out_ready,
    output      logic                        coeff_we,
    output      logic [fir_rate_pkg::CW-1:0] coeff_data_in,
    output      logic                        coeff_load_set
);
    import fir_rate_pkg::*;
    // ------------------------------------------------------------
    // Stream sides
    // ------------------------------------------------------------
    initial begin
        in_valid = 1'b0;
        coeff_we = 1'b0;
        coeff_data_in = '0;
        coeff_load_set = 1'b0;
    end
    assign out_ready = sink_on;
    assign in_data = in_valid ? src_value : ~src_value;
    // Valid is only withdrawn after a take
    always @(posedge pclk) begin
        if (src_on) begin
            in_valid <= 1'b1;
        end else if (in_ready) begin
            in_valid <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // Loader: word 0 zero, word 1 w1, rest wn
    // ------------------------------------------------------------
    task automatic load(input logic st, input int lead, input int nw,
                        input logic [CW-1:0] w1, input logic [CW-1:0] wn);
        int k;
        @(posedge pclk);
        coeff_load_set <= st;
        repeat (2) @(posedge pclk);
        coeff_we <= 1'b1;
        for (k = 0; k < lead - 1; k++) @(posedge pclk);
        for (k = 0; k < nw; k++) begin
            @(posedge pclk);
            coeff_data_in <= (k == 0) ? '0 : (k == 1) ? w1 : wn;
        end
        @(posedge pclk);
        coeff_we <= 1'b0;
        coeff_data_in <= ~coeff_data_in;
        @(posedge pclk);
        coeff_load_set <= ~st;
    endtask
endmodule

// file: testbench/testbench.sv
// Purpose: Self-checking bench of the FIR rate engine and reload port
// Assumes: Register layout as in the package constants
// Notes:   Rates are judged from the last gap between transfers
`timescale 1ns/10ps
module testbench;
    import fir_rate_pkg::*;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          ce = 1'b1;
    logic [11:0]   paddr = '0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [31:0]   pwdata = '0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          in_valid;
    logic          in_ready;
    logic [DW-1:0] in_data;
    logic          out_valid;
    logic          out_ready;
    beat_t         out_beat;
    logic          coeff_we;
    logic [CW-1:0] coeff_data_in;
    logic          coeff_load_set;
    logic          coeff_compute_set = 1'b0;
    logic          src_on = 1'b0;
    logic          sink_on = 1'b1;
    logic          chk_chan = 1'b0;
    int            err_count = 0;
    int            cmp_count = 0;
    int            cyc = 0;
    int            in_last = 0;
    int            out_last = 0;
    int            in_gap = 0;
    int            out_gap = 0;
    int            in_cnt = 0;
    int            out_cnt = 0;
    int            exp_chan = 0;

    always #25 pclk = ~pclk;

    fir_rate_core uut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
        .out_ready(out_ready), .out_beat(out_beat), .coeff_we(coeff_we),
        .coeff_data_in(coeff_data_in), .coeff_load_set(coeff_load_set),
        .coeff_compute_set(coeff_compute_set));

    fir_partner fp (.pclk(pclk), .src_on(src_on), .sink_on(sink_on),
        .src_value(16'h0100), .in_ready(in_ready), .in_valid(in_valid),
        .in_data(in_data), .out_ready(out_ready), .coeff_we(coeff_we),
        .coeff_data_in(coeff_data_in), .coeff_load_set(coeff_load_set));
    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_count++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (in_valid && in_ready) begin
            in_gap <= cyc - in_last;
            in_last <= cyc;
            in_cnt <= in_cnt + 1;
        end
        if (out_valid && out_ready) begin
            out_gap <= cyc - out_last;
            out_last <= cyc;
            out_cnt <= out_cnt + 1;
            if (chk_chan) begin
                check("chan", 32'(out_beat.chan), exp_chan);
                check("sop", 32'(out_beat.sop), 32'(exp_chan == 0));
                check("eop", 32'(out_beat.eop), 32'(exp_chan == 2));
                exp_chan = (exp_chan == 2) ? 0 : exp_chan + 1;
            end
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic regs_scn();
        logic [31:0] r;
        logic        e;
        apb(MODE_OFF, 1'b0, '0, r, e);
        check("mode reset", r, MODE_RESET);
        apb(SHAPE_OFF, 1'b0, '0, r, e);
        check("shape reset", r, SHAPE_RESET);
        wr(MODE_OFF, 32'hffff_ffff);
        apb(MODE_OFF, 1'b0, '0, r, e);
        check("mode mask", r, MODE_MASK);
        apb(12'h010, 1'b0, '0, r, e);
        check("unmapped err", 32'(e), 32'h1);
        check("unmapped data", r, 32'h0);
    endtask

    task automatic chan_scn();
        int o0;
        wr(SHAPE_OFF, 32'h0022_0812);
        wr(MODE_OFF, 32'h0);
        o0 = out_cnt;
        chk_chan = 1'b1;
        src_on <= 1'b1;
        repeat (30) @(posedge pclk);
        src_on <= 1'b0;
        repeat (20) @(posedge pclk);
        chk_chan = 1'b0;
        check("chan beats", 32'(out_cnt - o0 > 5), 32'h1);
        wr(SHAPE_OFF, SHAPE_RESET);
    endtask

    // up/dn give outputs per input; dn zero skips the count
    task automatic rate(input logic [31:0] md, input logic [31:0] sh, input int ig,
                        input int og, input int up, input int dn);
        int i0;
        int o0;
        wr(SHAPE_OFF, sh);
        wr(MODE_OFF, md);
        i0 = in_cnt;
        o0 = out_cnt;
        src_on <= 1'b1;
        repeat (80) @(posedge pclk);
        check("in gap", in_gap, ig);
        check("out gap", out_gap, og);
        src_on <= 1'b0;
        repeat (60) @(posedge pclk);
        if (dn > 0) begin
            check("out count", out_cnt - o0, (in_cnt - i0) * up / dn);
        end
    endtask

    task automatic stall_scn();
        beat_t held;
        int    i0;
        wr(MODE_OFF, 32'h0);
        src_on <= 1'b1;
        repeat (10) @(posedge pclk);
        sink_on <= 1'b0;
        repeat (3) @(posedge pclk);
        held = out_beat;
        i0 = in_cnt;
        repeat (6) @(posedge pclk);
        check("stall valid", 32'(out_valid), 32'h1);
        check("stall beat", 32'(out_beat), 32'(held));
        check("stall take", in_cnt, i0);
        src_on <= 1'b0;
        sink_on <= 1'b1;
        repeat (20) @(posedge pclk);
        check("drained", 32'(out_valid), 32'h0);
    endtask

    task automatic expect_out(input logic [15:0] exp);
        int n;
        src_on <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (out_valid !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            end_of_test();
        end
        check("out data", 32'(out_beat.data), 32'(exp));
        src_on <= 1'b0;
        repeat (20) @(posedge pclk);
    endtask

    // Aborted load first: a missed clear would land word 14 on index 1
    task automatic reload_scn();
        wr(MODE_OFF, 32'h0);
        ce <= 1'b0;
        fp.load(1'b1, LEAD_PAR, 3, 16'h6000, 16'h6000);
        fp.load(1'b1, LEAD_PAR, 16, 16'h4000, 16'h2000);
        ce <= 1'b1;
        coeff_compute_set <= 1'b1;
        expect_out(16'h0080);
        wr(MODE_OFF, 32'h2);
        fp.load(1'b0, LEAD_MEM, 4, 16'h2000, 16'h1000);
        coeff_compute_set <= 1'b0;
        expect_out(16'h0040);
        wr(MODE_OFF, 32'h10);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        expect_out(16'h0000);
    endtask

    initial begin
        #5000000;
        err_count++;
        end_of_test();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        regs_scn();
        chan_scn();
        stall_scn();
        rate(32'h04, 32'h0002_0812, 2, 1, 2, 1);
        rate(32'h08, 32'h0002_0812, 1, 2, 1, 2);
        rate(32'h05, 32'h0002_0832, 6, 3, 0, 0);
        rate(32'h09, 32'h0002_0832, 3, 6, 0, 0);
        rate(32'h0b, 32'h0002_0812, 4, 8, 0, 0);
        rate(32'h02, 32'h0002_0812, 9, 9, 0, 0);
        reload_scn();
        end_of_test();
    end
endmodule
